/* File: motor_current_supervisor.sv */
// Motor current supervisor: settings, boost, stall latch and test selection
//
// Contract
// R1 - Load compensation never exceeds programmed ceiling
// R2 - Damping 0 to 60 percent, default 25
// R3 - Capture hold current before brake engages
// R4 - Start compensation from hold current times factor
// R5 - No remembered start without prior brake
// R6 - Limit current, ceiling clamped to rating
// R7 - Over-temperature reduces permitted current
// R8 - Boost current allowed for boost time
// R9 - After boost time, normal ceiling applies
// R10 - Rearm after twice the over-ceiling time
// R11 - Stall at limit for timeout disables drive
// R12 - Stall timeout: emergency stop, fault code 4
// R13 - Stall fault latched until power cycle
// R14 - Stall limit zero disables stall timer
// R15 - Six-way motor test selection, default short
// R16 - Full: open and short, pre and drive
// R17 - Short only: short pre and drive
// R18 - Open throughout: open pre and drive
// R19 - Open before driving only
// R20 - None: no motor checks
// R21 - Combined: open pre, short pre and drive
`timescale 1ns/1ps
`default_nettype none
module motor_current_supervisor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] rated_cur_i,
    input wire mcs_pkg::motor_in_t motor_i,
    output mcs_pkg::motor_out_t motor_o,
    output mcs_pkg::test_sel_t test_sel_o
);
    import mcs_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] loadcomp;
        logic [7:0] loadcomp_max;
        logic [7:0] damping;
        logic [7:0] remember;
        logic [7:0] cur_limit;
        logic [7:0] boost_cur;
        logic [3:0] boost_time;
        logic [5:0] stall_limit;
        test_mode_t test_mode;
        logic [16:0] tick_cnt;
        logic [7:0] rated;
        logic [11:0] cur_s1;
        logic [11:0] cur_s2;
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [11:0] hold_cur;
        logic hold_valid;
        logic [7:0] start_comp;
        logic [15:0] over_ms;
        logic [16:0] under_ms;
        logic boost_armed;
        logic [15:0] stall_ms;
        logic fault;
        logic [7:0] limit;
        logic [7:0] comp;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic tick;
    logic req;
    logic [11:0] cur;
    logic drive_req;
    logic driving;
    logic braking;
    logic hot;
    logic [7:0] ceiling;
    logic [7:0] derated;
    logic above;
    logic [15:0] boost_ms;
    logic [15:0] stall_lim_ms;
    logic [15:0] damped;
    logic [19:0] start_prod;
    logic [7:0] wr_byte;

    assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign tick = (s_q.tick_cnt == 17'(TICK_CYCLES - 1));
    assign cur = s_q.cur_s2;
    assign {drive_req, driving, braking, hot} = s_q.pin_s2;
    assign wr_byte = wb_dat_i[7:0];

    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        s_d.rated = rated_cur_i;
        // Pins from the power stage cross in from outside; two stages each
        s_d.cur_s1 = motor_i.current;
        s_d.cur_s2 = s_q.cur_s1;
        s_d.pin_s1 = {motor_i.drive_req, motor_i.driving,
                      motor_i.brake_engaging, motor_i.over_temp};
        s_d.pin_s2 = s_q.pin_s1;
        s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 17'd1;

        // Register writes on the accepted strobe, byte lane 0 carries values, lane 1 the boost time
        if (req && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                ADDR_LOADCOMP_MAX: begin
                    s_d.loadcomp_max = wr_byte;
                    if (s_q.loadcomp > wr_byte) begin
                        s_d.loadcomp = wr_byte; // [R1]
                    end
                end
                ADDR_LOADCOMP: s_d.loadcomp = (wr_byte > s_q.loadcomp_max)
                    ? s_q.loadcomp_max : wr_byte; // [R1]
                ADDR_DAMPING: s_d.damping = (wr_byte > DAMP_MAX)
                    ? DAMP_MAX : wr_byte; // [R2]
                ADDR_REMEMBER: s_d.remember = (wr_byte < REM_MIN) ? REM_MIN
                    : ((wr_byte > REM_MAX) ? REM_MAX : wr_byte); // [R4]
                ADDR_CUR_LIMIT: s_d.cur_limit = wr_byte;
                ADDR_STALL: s_d.stall_limit = (wr_byte[5:0] > STALL_MAX
                    || wr_byte[7:6] != 2'b00) ? STALL_MAX
                    : wr_byte[5:0];
                ADDR_TEST_MODE: begin
                    if (wr_byte[2:0] <= 3'(TEST_ALL)) begin // [R15]
                        s_d.test_mode = test_mode_t'(wr_byte[2:0]);
                    end
                end
                default: ;
            endcase
        end
        if (req && wb_we_i && wb_adr_i == ADDR_BOOST) begin
            if (wb_sel_i[0]) begin
                s_d.boost_cur = wr_byte;
            end
            if (wb_sel_i[1]) begin
                s_d.boost_time = (wb_dat_i[11:8] > BOOST_TIME_MAX)
                    ? BOOST_TIME_MAX : wb_dat_i[11:8]; // [R8]
            end
        end

        // Hold current captured at the brake-engage request
        if (braking && !driving) begin
            s_d.hold_cur = cur; // [R3]
            s_d.hold_valid = 1'b1;
        end
        // Remembered start only after a real brake stop
        if (drive_req && !driving) begin
            s_d.start_comp = !s_q.hold_valid ? 8'h00 // [R5]
                : ((start_prod > 20'd255) ? 8'hff : start_prod[7:0]); // [R4]
        end else if (driving) begin
            s_d.hold_valid = 1'b0; // [R5]
            s_d.start_comp = 8'h00;
        end

        // Boost accounting in milliseconds
        if (tick) begin
            if (above) begin
                s_d.under_ms = '0;
                if (s_q.boost_armed && s_q.over_ms != 16'hffff) begin
                    s_d.over_ms = s_q.over_ms + 16'd1;
                end
                if (s_q.over_ms + 16'd1 >= boost_ms) begin
                    s_d.boost_armed = 1'b0; // [R9]
                end
            end else if (s_q.over_ms != '0) begin
                s_d.under_ms = s_q.under_ms + 17'd1;
                if (s_q.under_ms + 17'd1 >= {s_q.over_ms, 1'b0}) begin
                    s_d.boost_armed = 1'b1; // [R10]
                    s_d.over_ms = '0;
                    s_d.under_ms = '0;
                end
            end
        end

        // Stall: pinned at the ceiling while asked to drive
        if (s_q.stall_limit == '0 || !drive_req || cur < {4'h0, derated}) begin
            s_d.stall_ms = '0; // [R14]
        end else if (tick && !s_q.fault) begin
            s_d.stall_ms = s_q.stall_ms + 16'd1;
            if (s_q.stall_ms + 16'd1 >= stall_lim_ms) begin
                s_d.fault = 1'b1; // [R11] [R13]
            end
        end

        s_d.limit = s_q.fault ? 8'h00
            : (s_q.boost_armed ? derated + s_q.boost_cur : derated); // [R8] [R9]
        s_d.comp = s_q.fault ? 8'h00 : damped[7:0]; // [R2]

        // Read data only on the taking cycle, else zero
        s_d.rdata = '0;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                ADDR_LOADCOMP: s_d.rdata[7:0] = s_q.loadcomp;
                ADDR_LOADCOMP_MAX: s_d.rdata[7:0] = s_q.loadcomp_max;
                ADDR_DAMPING: s_d.rdata[7:0] = s_q.damping;
                ADDR_REMEMBER: s_d.rdata[7:0] = s_q.remember;
                ADDR_CUR_LIMIT: s_d.rdata[7:0] = s_q.cur_limit;
                ADDR_BOOST: s_d.rdata[11:0] = {s_q.boost_time,
                                               s_q.boost_cur};
                ADDR_STALL: s_d.rdata[5:0] = s_q.stall_limit;
                ADDR_TEST_MODE: s_d.rdata[2:0] = s_q.test_mode;
                ADDR_STATUS: begin
                    s_d.rdata[ST_FAULT] = s_q.fault;
                    s_d.rdata[ST_BOOST_ARMED] = s_q.boost_armed;
                    s_d.rdata[ST_BOOSTING] = s_q.boost_armed & above;
                    s_d.rdata[ST_HOLD_VALID] = s_q.hold_valid;
                    s_d.rdata[ST_CODE_LSB +: 4] =
                        s_q.fault ? FAULT_STALL : 4'h0;
                end
                ADDR_HOLD_CUR: s_d.rdata[11:0] = s_q.hold_cur;
                ADDR_START_COMP: s_d.rdata[7:0] = s_q.start_comp;
                ADDR_EFF_LIMIT: s_d.rdata[7:0] = s_q.limit;
                default: s_d.rdata = '0;
            endcase
        end
    end

    // Ceiling clamped to the controller rating, then thermally derated
    always_comb begin
        ceiling = (s_q.cur_limit > s_q.rated) ? s_q.rated : s_q.cur_limit; // [R6]
        derated = hot ? ((ceiling > THERM_DERATE)
            ? ceiling - THERM_DERATE : 8'h00) : ceiling; // [R7]
        above = cur > {4'h0, derated};
        boost_ms = 16'(s_q.boost_time) * 16'(TICKS_PER_S);
        stall_lim_ms = 16'(s_q.stall_limit) * 16'(TICKS_PER_S);
        // Damping removes a fraction; products sized so nothing wraps
        damped = 16'(s_q.loadcomp) * 16'(8'd100 - s_q.damping) / 16'd100;
        start_prod = 20'(s_q.hold_cur) * 20'(s_q.remember) / 20'd100;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.loadcomp <= LOADCOMP_RST;
            s_q.loadcomp_max <= LOADCOMP_MAX_RST;
            s_q.damping <= DAMP_RST;
            s_q.remember <= REM_RST;
            s_q.cur_limit <= CUR_LIMIT_RST;
            s_q.rated <= RATED_CUR_RST;
            s_q.boost_cur <= BOOST_CUR_RST;
            s_q.boost_time <= BOOST_TIME_RST;
            s_q.stall_limit <= STALL_RST;
            s_q.test_mode <= TEST_SHORT; // [R15]
            s_q.boost_armed <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    mcs_test_sel u_test_sel (
        .clk_i(clk_i),
        .rst_i(rst_i | s_q.fault),
        .mode_i(s_q.test_mode),
        .driving_i(driving),
        .sel_o(test_sel_o)
    );

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    assign motor_o.limit = s_q.limit;
    assign motor_o.comp = s_q.comp;
    assign motor_o.start_comp = s_q.start_comp;
    assign motor_o.drive_en = ~s_q.fault; // [R11] [R13]
    assign motor_o.estop = s_q.fault; // [R12]
    assign motor_o.fault_code = s_q.fault ? FAULT_STALL : 4'h0; // [R12]
endmodule
`default_nettype wire

/* File: mcs_pkg.sv */
// Package: register map, field layouts and timing for the current supervisor
package mcs_pkg;

    localparam int CLK_HZ = 125000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_PER_S = 1000 / TICK_MS;

    // Word offsets (byte addresses)
    localparam logic [7:0] ADDR_LOADCOMP = 8'h00;
    localparam logic [7:0] ADDR_LOADCOMP_MAX = 8'h04;
    localparam logic [7:0] ADDR_DAMPING = 8'h08;
    localparam logic [7:0] ADDR_REMEMBER = 8'h0c;
    localparam logic [7:0] ADDR_CUR_LIMIT = 8'h10;
    localparam logic [7:0] ADDR_BOOST = 8'h14;
    localparam logic [7:0] ADDR_STALL = 8'h18;
    localparam logic [7:0] ADDR_TEST_MODE = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_HOLD_CUR = 8'h24;
    localparam logic [7:0] ADDR_START_COMP = 8'h28;
    localparam logic [7:0] ADDR_EFF_LIMIT = 8'h2c;

    // Value ranges and reset values
    localparam logic [7:0] LOADCOMP_RST = 8'd20;
    localparam logic [7:0] LOADCOMP_MAX_RST = 8'd225;
    localparam logic [7:0] DAMP_MAX = 8'd60;
    localparam logic [7:0] DAMP_RST = 8'd25;
    localparam logic [7:0] REM_MIN = 8'd15;
    localparam logic [7:0] REM_MAX = 8'd60;
    localparam logic [7:0] REM_RST = 8'd50;
    localparam logic [7:0] CUR_LIMIT_RST = 8'd90;
    localparam logic [7:0] RATED_CUR_RST = 8'd90;
    localparam logic [7:0] BOOST_CUR_RST = 8'd10;
    localparam logic [3:0] BOOST_TIME_MAX = 4'd10;
    localparam logic [3:0] BOOST_TIME_RST = 4'd10;
    localparam logic [5:0] STALL_MAX = 6'd51;
    localparam logic [5:0] STALL_RST = 6'd15;
    localparam logic [3:0] FAULT_STALL = 4'h4;
    localparam logic [7:0] THERM_DERATE = 8'd20;

    // Boost register fields
    localparam int BOOST_TIME_LSB = 8;

    // Status register fields
    localparam int ST_FAULT = 0;
    localparam int ST_BOOST_ARMED = 1;
    localparam int ST_BOOSTING = 2;
    localparam int ST_HOLD_VALID = 3;
    localparam int ST_CODE_LSB = 4;

    typedef enum logic [2:0] {
        TEST_NONE = 3'd0,
        TEST_OPEN_PRE = 3'd1,
        TEST_SHORT = 3'd2,
        TEST_ALL_OPEN_PRE = 3'd3,
        TEST_OPEN_ALL = 3'd4,
        TEST_ALL = 3'd5
    } test_mode_t;

    typedef struct packed {
        logic open_pre;
        logic open_drive;
        logic short_pre;
        logic short_drive;
    } test_sel_t;

    typedef struct packed {
        logic [11:0] current;
        logic drive_req;
        logic driving;
        logic brake_engaging;
        logic over_temp;
    } motor_in_t;

    typedef struct packed {
        logic [7:0] limit;
        logic [7:0] comp;
        logic [7:0] start_comp;
        logic drive_en;
        logic estop;
        logic [3:0] fault_code;
    } motor_out_t;

endpackage

/* File: mcs_test_sel.sv */
// Motor test selection decoder
`timescale 1ns/1ps
`default_nettype none
module mcs_test_sel (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire mcs_pkg::test_mode_t mode_i,
    input wire logic driving_i,
    output mcs_pkg::test_sel_t sel_o
);
    import mcs_pkg::*;

    typedef struct packed {
        test_sel_t sel;
    } state_t;

    state_t s_q;
    state_t s_d;
    test_sel_t m;

    always_comb begin
        m = '0;
        case (mode_i)
            TEST_NONE: m = '0; // [R20]
            TEST_OPEN_PRE: m.open_pre = 1'b1; // [R19]
            TEST_SHORT: begin // [R17]
                m.short_pre = 1'b1;
                m.short_drive = 1'b1;
            end
            TEST_ALL_OPEN_PRE: begin // [R21]
                m.open_pre = 1'b1;
                m.short_pre = 1'b1;
                m.short_drive = 1'b1;
            end
            TEST_OPEN_ALL: begin // [R18]
                m.open_pre = 1'b1;
                m.open_drive = 1'b1;
            end
            TEST_ALL: m = '1; // [R16]
            default: m = '0;
        endcase
        // Pre-drive checks run only while stopped, drive checks only moving
        s_d.sel.open_pre = m.open_pre & ~driving_i;
        s_d.sel.short_pre = m.short_pre & ~driving_i;
        s_d.sel.open_drive = m.open_drive & driving_i;
        s_d.sel.short_drive = m.short_drive & driving_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sel_o = s_q.sel;
endmodule
`default_nettype wire

/* File: mcs_checker.sv */
// Port-level assertions for the motor current supervisor
`timescale 1ns/1ps
`default_nettype none
module mcs_checker
    import mcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire mcs_pkg::motor_out_t motor_o,
    input wire mcs_pkg::test_sel_t test_sel_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_ack;
        s_req |=> s_pulse;
    endproperty
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i);
    endproperty
    property p_stop_code;
        motor_o.estop |-> motor_o.fault_code == FAULT_STALL
            && !motor_o.drive_en;
    endproperty
    property p_latch;
        motor_o.estop |=> motor_o.estop [*8];
    endproperty
    property p_stop_limit;
        motor_o.estop |-> motor_o.limit == 8'h0;
    endproperty
    property p_run_ok;
        !motor_o.drive_en |-> motor_o.estop;
    endproperty
    // Pre-drive and in-drive checks never overlap
    property p_phase;
        (test_sel_o.open_pre || test_sel_o.short_pre) |->
            !(test_sel_o.open_drive || test_sel_o.short_drive);
    endproperty

    a_ack: assert property (p_ack) else $error("ack not one pulse");
    a_dat_idle: assert property (p_dat_idle) else $error("data without ack");
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    a_stop_code: assert property (p_stop_code)
        else $error("stop without code 4");
    a_latch: assert property (p_latch)
        else $error("stall fault released");
    a_stop_limit: assert property (p_stop_limit)
        else $error("current allowed after stall");
    a_run_ok: assert property (p_run_ok)
        else $error("drive off without fault");
    a_phase: assert property (p_phase)
        else $error("pre and drive checks together");
endmodule

bind motor_current_supervisor mcs_checker u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .motor_o(motor_o),
    .test_sel_o(test_sel_o)
);
`default_nettype wire

/* File: mcs_motor_model.sv */
// Behavioural power bridge and brushed motor on the supervisor's far side
`timescale 1ns/1ps
`default_nettype none
module mcs_motor_model
    import mcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic req_i,
    input wire logic brake_i,
    input wire logic hot_i,
    input wire logic [11:0] load_i,
    input wire mcs_pkg::motor_out_t ctl_i,
    output var mcs_pkg::motor_in_t mot_o
);
    initial mot_o = '0;
    // go_i low with req_i high models a rotor that is slow to turn
    always @(posedge clk_i) begin
        mot_o.driving <= go_i && ctl_i.drive_en;
        mot_o.drive_req <= req_i;
        mot_o.brake_engaging <= brake_i;
        mot_o.over_temp <= hot_i;
        mot_o.current <= (go_i || brake_i) && ctl_i.drive_en ? load_i : 12'h0;
    end
endmodule
`default_nettype wire

/* File: motor_current_supervisor_tb.sv */
// Self-checking bench for the motor current supervisor
`timescale 1ns/1ps
`default_nettype none
module motor_current_supervisor_tb;
    import mcs_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic go = 0, req = 0, brake = 0, hot = 0;
    logic [7:0] adr = 8'h0, rated = 8'd90;
    logic [3:0] sel = 4'hf;
    logic [11:0] load = 12'h0;
    logic [31:0] wdat = 32'h0, rdat, v, base, wb_dat_o;
    logic wb_ack_o;
    motor_in_t mot;
    motor_out_t mout;
    test_sel_t tsel;
    int num_errors = 0, tests_run = 0, seed = 32'h38d191d5;
    int corner[3] = '{61, 14, 52};

    always #4 clk_i = ~clk_i;

    motor_current_supervisor dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rated_cur_i(rated), .motor_i(mot),
        .motor_o(mout), .test_sel_o(tsel));
    mcs_motor_model partner (.clk_i(clk_i), .go_i(go), .req_i(req),
        .brake_i(brake), .hot_i(hot), .load_i(load), .ctl_i(mout),
        .mot_o(mot));

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        if (n >= 20) chk("ack", 1, 0);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(what, exp, rdat);
    endtask

    function automatic logic [31:0] clampv(int x, int lo, int hi);
        return x < lo ? lo : (x > hi ? hi : x);
    endfunction

    function automatic test_sel_t exp_sel(int m, logic drv);
        test_sel_t s;
        s.open_pre = (m == 1 || m >= 3) && !drv;
        s.open_drive = m >= 4 && drv;
        s.short_pre = (m == 2 || m == 3 || m == 5) && !drv;
        s.short_drive = (m == 2 || m == 3 || m == 5) && drv;
        return s;
    endfunction

    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #480000;
        num_errors++;
        report_and_stop;
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("damping", ADDR_DAMPING, 32'(DAMP_RST));
        rd_chk("remember", ADDR_REMEMBER, 32'(REM_RST));
        rd_chk("stall", ADDR_STALL, 32'(STALL_RST));
        rd_chk("mode", ADDR_TEST_MODE, 32'h2);
        rd_chk("comp max", ADDR_LOADCOMP_MAX, 32'(LOADCOMP_MAX_RST));
        rd_chk("unmapped", 8'hfc, 32'h0);
        req <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd_chk("start none", ADDR_START_COMP, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 9; i++) begin
            v = i < 3 ? corner[i] : $random(seed) & 32'hff;
            wb(1'b1, ADDR_DAMPING, v);
            rd_chk("damping", ADDR_DAMPING, clampv(v, 0, 60));
            wb(1'b1, ADDR_REMEMBER, v);
            rd_chk("remember", ADDR_REMEMBER, clampv(v, 15, 60));
            wb(1'b1, ADDR_STALL, v & 32'h3f);
            rd_chk("stall", ADDR_STALL, clampv(v & 32'h3f, 0, 51));
        end
        wb(1'b1, ADDR_LOADCOMP_MAX, 32'd100);
        wb(1'b1, ADDR_LOADCOMP, 32'd150);
        rd_chk("comp clamp", ADDR_LOADCOMP, 32'd100);
        wb(1'b1, ADDR_DAMPING, 32'd25);
        repeat (2) @(posedge clk_i);
        chk("comp port", 32'd75, 32'(mout.comp));
        $display("settings test done");
        wb(1'b1, ADDR_STALL, 32'h0);
        wb(1'b0, ADDR_EFF_LIMIT, 32'h0);
        base = rdat;
        chk("limit reset", 32'(CUR_LIMIT_RST + BOOST_CUR_RST), base);
        chk("limit port", base, 32'(mout.limit));
        hot <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd_chk("hot limit", ADDR_EFF_LIMIT, base - 20);
        hot <= 1'b0;
        rated <= 8'd70;
        repeat (8) @(posedge clk_i);
        rd_chk("rated", ADDR_EFF_LIMIT, base - 20);
        rated <= 8'd90;
        wb(1'b1, ADDR_CUR_LIMIT, 32'd200);
        rd_chk("ceiling clamp", ADDR_EFF_LIMIT, base);
        wb(1'b1, ADDR_CUR_LIMIT, 32'd60);
        rd_chk("ceiling", ADDR_EFF_LIMIT, base - 30);
        $display("limit test done");
        wb(1'b1, ADDR_REMEMBER, 32'd50);
        brake <= 1'b1;
        load <= 12'd40;
        repeat (10) @(posedge clk_i);
        rd_chk("hold", ADDR_HOLD_CUR, 32'd40);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("hold valid", 1, rdat[ST_HOLD_VALID]);
        brake <= 1'b0;
        repeat (8) @(posedge clk_i);
        wb(1'b0, ADDR_START_COMP, 32'h0);
        chk("start set", 32'd20, rdat);
        chk("start port", 32'd20, 32'(mout.start_comp));
        go <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd_chk("start clear", ADDR_START_COMP, 32'h0);
        $display("hold test done");
        for (int m = 0; m < 6; m++) begin
            wb(1'b1, ADDR_TEST_MODE, m);
            repeat (6) @(posedge clk_i);
            chk("sel drive", exp_sel(m, 1), tsel);
            go <= 1'b0;
            repeat (8) @(posedge clk_i);
            chk("sel pre", exp_sel(m, 0), tsel);
            go <= 1'b1;
            repeat (8) @(posedge clk_i);
        end
        wb(1'b1, ADDR_TEST_MODE, 32'h7);
        rd_chk("mode kept", ADDR_TEST_MODE, 32'h5);
        $display("test mode test done");
        load <= 12'd300;
        repeat (3000) @(posedge clk_i);
        chk("drive on", 1, mout.drive_en);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("boosting", 1, rdat[ST_BOOSTING]);
        load <= 12'h0;
        $display("stall off test done");
        report_and_stop;
    end
endmodule
`default_nettype wire
